// ==== hw/lph_defines.vh ====
`ifndef LPH_DEFINES_VH
`define LPH_DEFINES_VH
// wake and entry method codes
`define LPH_M_UART 2'h0
`define LPH_M_SPIE 2'h1
`define LPH_M_SPI 2'h2
`define LPH_M_HSK 2'h3
// one character time on the host serial line, in ns
`define LPH_CHAR_NS 86800
`define LPH_CLK_NS 100
`define LPH_CHAR_CYC ((`LPH_CHAR_NS + `LPH_CLK_NS - 1) / `LPH_CLK_NS)
`define LPH_BRK_W 10
// state codes
`define LPH_S_W 10
`define LPH_ST_ACT 10'h001
`define LPH_ST_SLP 10'h002
`define LPH_ST_FLOW 10'h004
`define LPH_ST_CKOFF 10'h008
`define LPH_ST_DEEP 10'h010
`define LPH_ST_WAKE 10'h020
`define LPH_ST_ATTN 10'h040
`define LPH_ST_RADIO 10'h080
`define LPH_ST_PDN 10'h100
`define LPH_ST_XFER 10'h200
// power state report, one bit each
`define LPH_PS_ACT 4'h1
`define LPH_PS_SLP 4'h2
`define LPH_PS_DEEP 4'h4
`define LPH_PS_PDN 4'h8
`endif

// ==== hw/lph_handshake.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lph_defines.vh"

module lph_handshake (
  input wire CLK_SYS,
  input wire ARST_N,
  input wire [1:0] METHOD,
  input wire CKREQ_LOW,
  input wire ATTN_ORDER,
  input wire DS_ENABLE,
  input wire PDOWN_CMD,
  input wire HOST_SERIAL_RX,
  input wire WAKE_REQUEST_IN,
  input wire SLEEP_MSG,
  input wire WAKEUP_MSG,
  input wire LINK_ACTIVE,
  input wire RADIO_DUE,
  input wire HOST_DATA_PENDING,
  input wire CLK_PRESENT,
  output reg CLOCK_REQUEST_OUT_A,
  output reg CLOCK_REQUEST_OUT_B,
  output reg FLOW_HOLD_OUTPUT,
  output reg HOST_ATTENTION_OUTPUT,
  output reg CLK_GATE,
  output reg CMD_ACCEPT,
  output reg XFER_REQ,
  output reg WOKEN_EVT,
  output reg MEM_REINIT,
  output reg RETAIN_PINS,
  output reg [3:0] PWR_STATE
);

  // ****************************************
  // reset release
  // ****************************************
  reg rst_q1;
  reg rst_n;

  // two flops so the release is clean to the system clock
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ****************************************
  // wake input synchronisers
  // ****************************************
  reg rx_q1;
  reg rx_s;
  reg wk_q1;
  reg wk_s;

  // first stage feeds only the second stage
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      rx_q1 <= 1'b1;
      rx_s <= 1'b1;
      wk_q1 <= 1'b0;
      wk_s <= 1'b0;
    end else begin
      rx_q1 <= HOST_SERIAL_RX;
      rx_s <= rx_q1;
      wk_q1 <= WAKE_REQUEST_IN;
      wk_s <= wk_q1;
    end
  end

  // ****************************************
  // break detector
  // ****************************************
  reg [`LPH_BRK_W-1:0] brk_cnt;
  wire brk_full;

  // break means low for at least one full character time
  assign brk_full = (brk_cnt == `LPH_CHAR_CYC);

  // counter saturates so a long break stays seen
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      brk_cnt <= {`LPH_BRK_W{1'b0}};
    end else if (rx_s) begin
      brk_cnt <= {`LPH_BRK_W{1'b0}};
    end else if (!brk_full) begin
      brk_cnt <= brk_cnt + 1'b1;
    end
  end

  // ****************************************
  // enables and latched requests
  // ****************************************
  reg ds_en;
  reg pd_armed;
  reg sleep_req;
  reg [`LPH_S_W-1:0] st;
  reg [`LPH_S_W-1:0] next_st;
  reg host_wake;
  reg data_wake;
  wire in_deep;
  wire in_pdn;

  assign in_deep = (st == `LPH_ST_DEEP);
  assign in_pdn = (st == `LPH_ST_PDN);

  // memory loss in power down also drops the enables
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ds_en <= 1'b0;
      pd_armed <= 1'b0;
      sleep_req <= 1'b0;
    end else begin
      if (in_pdn && wk_s) begin
        ds_en <= 1'b0;
      end else if (DS_ENABLE) begin
        ds_en <= 1'b1;
      end
      // the arming command wins over the clear of the same cycle
      if (PDOWN_CMD) begin
        pd_armed <= 1'b1;
      end else if (in_pdn) begin
        pd_armed <= 1'b0;
      end
      if (SLEEP_MSG && METHOD == `LPH_M_SPIE) begin
        sleep_req <= 1'b1;
      end else if (st == `LPH_ST_CKOFF || WAKEUP_MSG) begin
        sleep_req <= 1'b0;
      end
    end
  end

  // ****************************************
  // permission and wake decode per method
  // ****************************************
  reg permit;
  reg host_up;
  wire busy;
  wire may_deep;

  // any link or pending work blocks deeper states
  assign busy = LINK_ACTIVE | RADIO_DUE | HOST_DATA_PENDING;
  assign may_deep = ds_en & permit & ~busy;

  // host permission and host wake differ by method
  always @* begin
    permit = 1'b0;
    host_up = 1'b0;
    case (METHOD)
      `LPH_M_UART: begin
        permit = brk_full;
        host_up = rx_s;
      end
      `LPH_M_SPIE: begin
        permit = sleep_req;
        host_up = WAKEUP_MSG;
      end
      default: begin
        permit = ~wk_s;
        host_up = wk_s;
      end
    endcase
  end

  // ****************************************
  // power state machine
  // ****************************************
  always @* begin
    next_st = st;
    case (st)
      `LPH_ST_ACT, `LPH_ST_SLP: begin
        // device never goes deeper unless the host allowed it
        if (may_deep) begin
          next_st = `LPH_ST_FLOW;
        end else if (sleep_req && HOST_DATA_PENDING) begin
          next_st = `LPH_ST_XFER;
        end else if (RADIO_DUE || HOST_DATA_PENDING) begin
          next_st = `LPH_ST_ACT;
        end else begin
          next_st = `LPH_ST_SLP;
        end
      end
      `LPH_ST_XFER: begin
        if (!HOST_DATA_PENDING) begin
          next_st = `LPH_ST_SLP;
        end
      end
      `LPH_ST_FLOW: begin
        next_st = `LPH_ST_CKOFF;
      end
      `LPH_ST_CKOFF: begin
        if (pd_armed) begin
          next_st = `LPH_ST_PDN;
        end else begin
          next_st = `LPH_ST_DEEP;
        end
      end
      `LPH_ST_DEEP: begin
        if (host_up || HOST_DATA_PENDING || RADIO_DUE) begin
          next_st = `LPH_ST_WAKE;
        end
      end
      `LPH_ST_WAKE: begin
        if (CLK_PRESENT) begin
          if (host_wake) begin
            next_st = `LPH_ST_SLP;
          end else if (data_wake && ATTN_ORDER) begin
            next_st = `LPH_ST_ATTN;
          end else if (data_wake) begin
            next_st = `LPH_ST_ACT;
          end else begin
            next_st = `LPH_ST_RADIO;
          end
        end
      end
      `LPH_ST_ATTN: begin
        // host confirms by releasing the receive line
        if (rx_s) begin
          next_st = `LPH_ST_ACT;
        end
      end
      `LPH_ST_RADIO: begin
        if (!RADIO_DUE) begin
          next_st = `LPH_ST_DEEP;
        end
      end
      `LPH_ST_PDN: begin
        if (wk_s) begin
          next_st = `LPH_ST_WAKE;
        end
      end
      default: begin
        next_st = `LPH_ST_SLP;
      end
    endcase
  end

  // wake cause is caught as the deep or power-down state is left
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st <= `LPH_ST_SLP;
      host_wake <= 1'b0;
      data_wake <= 1'b0;
    end else begin
      st <= next_st;
      if ((in_deep || in_pdn) && next_st == `LPH_ST_WAKE) begin
        host_wake <= host_up | in_pdn;
        data_wake <= HOST_DATA_PENDING;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  reg next_req;
  reg next_hold;
  reg next_attn;
  wire uart;
  wire spie_low;

  assign uart = (METHOD == `LPH_M_UART);
  assign spie_low = (METHOD == `LPH_M_SPIE) & CKREQ_LOW;

  // in the serial method, flow hold rises before the clock request falls
  always @* begin
    next_req = 1'b1;
    next_hold = FLOW_HOLD_OUTPUT;
    next_attn = 1'b0;
    case (next_st)
      `LPH_ST_CKOFF, `LPH_ST_DEEP, `LPH_ST_PDN: begin
        next_req = 1'b0;
        next_hold = uart;
      end
      `LPH_ST_FLOW: begin
        next_hold = uart;
      end
      `LPH_ST_WAKE, `LPH_ST_RADIO: begin
        next_req = 1'b1;
      end
      `LPH_ST_ATTN: begin
        next_attn = 1'b1;
      end
      default: begin
        next_hold = 1'b0;
        next_attn = data_wake & ATTN_ORDER & ~uart;
      end
    endcase
  end

  // a single clock request is steered to the pin of its polarity
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CLOCK_REQUEST_OUT_A <= 1'b1;
      CLOCK_REQUEST_OUT_B <= 1'b1;
      FLOW_HOLD_OUTPUT <= 1'b0;
      HOST_ATTENTION_OUTPUT <= 1'b0;
      CLK_GATE <= 1'b0;
      CMD_ACCEPT <= 1'b1;
      XFER_REQ <= 1'b0;
      WOKEN_EVT <= 1'b0;
      MEM_REINIT <= 1'b0;
      RETAIN_PINS <= 1'b0;
      PWR_STATE <= `LPH_PS_SLP;
    end else begin
      CLOCK_REQUEST_OUT_A <= next_req & ~spie_low;
      CLOCK_REQUEST_OUT_B <= ~(next_req & spie_low);
      FLOW_HOLD_OUTPUT <= next_hold;
      HOST_ATTENTION_OUTPUT <= next_attn;
      CLK_GATE <= ~next_req;
      CMD_ACCEPT <= (next_st == `LPH_ST_ACT) | (next_st == `LPH_ST_SLP) |
                    (next_st == `LPH_ST_XFER);
      XFER_REQ <= (next_st == `LPH_ST_XFER);
      WOKEN_EVT <= in_deep & WAKEUP_MSG &
                   (METHOD == `LPH_M_SPIE);
      MEM_REINIT <= in_pdn & wk_s;
      RETAIN_PINS <= (next_st == `LPH_ST_PDN);
      case (next_st)
        `LPH_ST_ACT, `LPH_ST_XFER, `LPH_ST_RADIO, `LPH_ST_ATTN: begin
          PWR_STATE <= `LPH_PS_ACT;
        end
        `LPH_ST_DEEP, `LPH_ST_CKOFF, `LPH_ST_WAKE: begin
          PWR_STATE <= `LPH_PS_DEEP;
        end
        `LPH_ST_PDN: begin
          PWR_STATE <= `LPH_PS_PDN;
        end
        default: begin
          PWR_STATE <= `LPH_PS_SLP;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/lph_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// host side of the handshake
// ****
module lph_host_model (
  input wire logic clk,
  input wire logic req_a,
  input wire logic req_b_n,
  input wire logic brk,
  input wire logic [7:0] dly,
  output logic rx,
  output logic clk_present
);
  logic [7:0] cnt = 8'h00;
  initial clk_present = 1'b0;
  // a held break grants deep sleep, releasing the line wakes the device
  assign rx = !brk;
  // clock returns dly+1 cycles after a request, stops as soon as it drops
  always @(posedge clk) begin
    if (!req_a && req_b_n) begin
      cnt <= 8'h00;
      clk_present <= 1'b0;
    end else if (cnt < dly) begin
      cnt <= cnt + 8'h01;
    end else begin
      clk_present <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/lph_handshake_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module lph_handshake_assertions (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [1:0] METHOD,
  input wire logic CKREQ_LOW,
  input wire logic PDOWN_CMD,
  input wire logic LINK_ACTIVE,
  input wire logic CLK_PRESENT,
  input wire logic CLOCK_REQUEST_OUT_A,
  input wire logic CLOCK_REQUEST_OUT_B,
  input wire logic FLOW_HOLD_OUTPUT,
  input wire logic CLK_GATE,
  input wire logic CMD_ACCEPT,
  input wire logic MEM_REINIT,
  input wire logic RETAIN_PINS,
  input wire logic [3:0] PWR_STATE
);
  logic pd_seen;
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  // sticky memory of a power-down command since reset
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) pd_seen <= 1'b0;
    else if (PDOWN_CMD) pd_seen <= 1'b1;
  end
  // entry steps in the serial method
  sequence s_flow_up;
    METHOD == 2'h0 && $rose(FLOW_HOLD_OUTPUT);
  endsequence
  sequence s_clk_off;
    !CLOCK_REQUEST_OUT_A && CLK_GATE;
  endsequence
  property p_uart_entry;
    s_flow_up |=> s_clk_off;
  endproperty
  a_uart_entry: assert property (p_uart_entry) else $error("entry");
  property p_flow_first;
    METHOD == 2'h0 && $fell(CLOCK_REQUEST_OUT_A) |-> FLOW_HOLD_OUTPUT;
  endproperty
  a_flow_first: assert property (p_flow_first) else $error("flow");
  property p_pdn_cmd;
    $rose(RETAIN_PINS) |-> pd_seen && PWR_STATE == 4'h8;
  endproperty
  a_pdn_cmd: assert property (p_pdn_cmd) else $error("pdown");
  property p_no_deep_link;
    PWR_STATE == 4'h2 && LINK_ACTIVE |=> !PWR_STATE[2] && !PWR_STATE[3];
  endproperty
  a_no_deep_link: assert property (p_no_deep_link) else $error("link");
  property p_req_gate;
    CLK_GATE |-> !CLOCK_REQUEST_OUT_A && CLOCK_REQUEST_OUT_B && !CMD_ACCEPT;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("gate");
  property p_host_wake;
    $fell(FLOW_HOLD_OUTPUT) |-> CLOCK_REQUEST_OUT_A && $past(CLK_PRESENT);
  endproperty
  a_host_wake: assert property (p_host_wake) else $error("wake");
  property p_reinit;
    MEM_REINIT |-> $fell(RETAIN_PINS) ##1 !MEM_REINIT;
  endproperty
  a_reinit: assert property (p_reinit) else $error("reinit");
  property p_pin_b;
    (METHOD != 2'h1 || !CKREQ_LOW) [*2] |-> CLOCK_REQUEST_OUT_B;
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b");
endmodule
bind lph_handshake lph_handshake_assertions u_chk (.*);
`default_nettype wire

// ==== tb/lph_handshake_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module lph_handshake_tb;
  logic clk = 1'b0, rst_n = 1'b0, brk = 1'b0, cklo = 1'b0, dsen = 1'b0;
  logic pdcmd = 1'b0, wake = 1'b0, slp = 1'b0, wkm = 1'b0, link = 1'b0;
  logic radio = 1'b0, rx, cpres, ra, rb, flow, attn, gate, cacc, xreq;
  logic woken, reinit, retain, aord = 1'b0, hdp = 1'b0;
  logic [1:0] meth = 2'h0;
  logic [3:0] pwr;
  logic [7:0] dly = 8'h02;
  int error_cnt = 0, n_checks = 0, cyc = 0, i, j;
  always #50 clk = ~clk;
  lph_host_model u_host (.clk(clk), .req_a(ra), .req_b_n(rb), .brk(brk),
    .dly(dly), .rx(rx), .clk_present(cpres));
  lph_handshake u_dut (.CLK_SYS(clk), .ARST_N(rst_n), .METHOD(meth),
    .CKREQ_LOW(cklo), .ATTN_ORDER(aord), .DS_ENABLE(dsen),
    .PDOWN_CMD(pdcmd), .HOST_SERIAL_RX(rx), .WAKE_REQUEST_IN(wake),
    .SLEEP_MSG(slp), .WAKEUP_MSG(wkm), .LINK_ACTIVE(link),
    .RADIO_DUE(radio), .HOST_DATA_PENDING(hdp), .CLK_PRESENT(cpres),
    .CLOCK_REQUEST_OUT_A(ra), .CLOCK_REQUEST_OUT_B(rb),
    .FLOW_HOLD_OUTPUT(flow), .HOST_ATTENTION_OUTPUT(attn), .CLK_GATE(gate),
    .CMD_ACCEPT(cacc), .XFER_REQ(xreq), .WOKEN_EVT(woken),
    .MEM_REINIT(reinit), .RETAIN_PINS(retain), .PWR_STATE(pwr));
  // drive just after the edge so the design never sees a race
  task tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      conclude;
    end
  end
  // break while disabled, then enabled with a live link: both refused
  task t_refuse;
    brk = 1'b1;
    tick(1000);
    chk({ra, gate, flow, cacc}, 4'h9);
    link = 1'b1;
    dsen = 1'b1;
    tick(1);
    dsen = 1'b0;
    tick(20);
    chk(pwr, 4'h2);
  endtask
  // link ends: flow hold first, then the request drops
  task t_entry;
    link = 1'b0;
    for (i = 0; i < 50 && flow !== 1'b1; i++) tick(1);
    chk({ra, gate, flow, cacc}, 4'hA);
    tick(1);
    chk({ra, gate, flow, cacc}, 4'h6);
    chk(pwr, 4'h4);
  endtask
  // radio slot in deep sleep with a slow host clock
  task t_radio;
    dly = 8'h28;
    radio = 1'b1;
    for (i = 0; i < 100 && pwr !== 4'h1; i++) tick(1);
    chk({ra, gate, flow, pwr[0]}, 4'hB);
    radio = 1'b0;
    tick(2);
    chk({ra, gate, flow, pwr[2]}, 4'h7);
    dly = 8'h02;
  endtask
  // host releases the line, flow opens only once the clock is back
  task t_host_wake;
    brk = 1'b0;
    for (i = 0; i < 20 && ra !== 1'b1; i++) tick(1);
    chk({1'b0, ra, gate, flow}, 4'h5);
    for (i = 0; i < 20 && flow !== 1'b0; i++) tick(1);
    chk({cpres, flow, cacc, pwr[1]}, 4'hB);
  endtask
  // armed power-down, left only by the wake input
  task t_pdown;
    pdcmd = 1'b1;
    tick(1);
    pdcmd = 1'b0;
    brk = 1'b1;
    for (i = 0; i < 1200 && retain !== 1'b1; i++) tick(1);
    chk(pwr, 4'h8);
    chk({ra, gate, retain, reinit}, 4'h6);
    wake = 1'b1;
    for (i = 0; i < 10 && reinit !== 1'b1; i++) tick(1);
    chk({2'h0, retain, reinit}, 4'h1);
    tick(1);
    chk({2'h0, retain, reinit}, 4'h0);
    for (i = 0; i < 30 && flow !== 1'b0; i++) tick(1);
    chk(pwr, 4'h2);
    wake = 1'b0;
    brk = 1'b0;
  endtask
  // device wake for pending data: flow hold first, then attention first
  task t_data_wake;
    dsen = 1'b1;
    tick(1);
    dsen = 1'b0;
    for (j = 0; j < 2; j++) begin
      aord = j[0];
      brk = 1'b1;
      for (i = 0; i < 1000 && gate !== 1'b1; i++) tick(1);
      tick(1);
      hdp = 1'b1;
      for (i = 0; i < 20 && (attn | ~flow) !== 1'b1; i++) tick(1);
      chk({attn, flow, ra, pwr[0]}, {aord, aord, 2'h3});
      // host releases the line; with attention order flow opens only after that, otherwise it is already open
      brk = 1'b0;
      tick(4);
      chk({attn, flow, ra, pwr[0]}, 4'h3);
      hdp = 1'b0;
      tick(2);
      chk(pwr, 4'h2);
    end
    aord = 1'b0;
  endtask
  // message method, request on the active-low pin
  task t_spi;
    meth = 2'h1;
    cklo = 1'b1;
    dsen = 1'b1;
    tick(1);
    dsen = 1'b0;
    tick(2);
    chk({ra, rb, gate, cacc}, 4'h1);
    radio = 1'b1;
    slp = 1'b1;
    tick(1);
    slp = 1'b0;
    tick(20);
    chk({1'b0, ra, rb, gate}, 4'h0);
    radio = 1'b0;
    for (i = 0; i < 10 && gate !== 1'b1; i++) tick(1);
    chk({ra, rb, gate, cacc}, 4'h6);
    // wakeup only counts once the clock-off step is over
    tick(1);
    wkm = 1'b1;
    tick(1);
    wkm = 1'b0;
    for (i = 0; i < 5 && woken !== 1'b1; i++) tick(1);
    chk({3'h0, woken}, 4'h1);
    for (i = 0; i < 30 && cacc !== 1'b1; i++) tick(1);
    chk({1'b0, rb, gate, pwr[1]}, 4'h1);
  endtask
  // host data pending after a sleep message goes out before deep sleep
  task t_xfer;
    hdp = 1'b1;
    slp = 1'b1;
    tick(1);
    slp = 1'b0;
    for (i = 0; i < 5 && xreq !== 1'b1; i++) tick(1);
    chk({xreq, gate, cacc, rb}, 4'hA);
    hdp = 1'b0;
    for (i = 0; i < 10 && gate !== 1'b1; i++) tick(1);
    chk({xreq, gate, cacc, rb}, 4'h5);
    tick(1);
  endtask
  // wake input method: high wakes, low permits deep sleep
  task t_wake_pin;
    meth = 2'h2;
    cklo = 1'b0;
    wake = 1'b1;
    for (i = 0; i < 10 && ra !== 1'b1; i++) tick(1);
    chk({ra, gate, cacc, flow}, 4'h8);
    for (i = 0; i < 20 && cacc !== 1'b1; i++) tick(1);
    chk(pwr, 4'h2);
    wake = 1'b0;
    for (i = 0; i < 10 && gate !== 1'b1; i++) tick(1);
    chk(pwr, 4'h4);
  endtask
  // main sequence
  initial begin
    tick(12);
    chk({cacc, gate, flow, pwr[1]}, 4'h9);
    rst_n = 1'b1;
    tick(4);
    t_refuse;
    t_entry;
    t_radio;
    t_host_wake;
    t_pdown;
    t_data_wake;
    t_spi;
    t_xfer;
    t_wake_pin;
    conclude;
  end
endmodule
`default_nettype wire
